// File: bst_defs.svh
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// ============================================================
// Instruction register
`define BST_IR_W        4
`define BST_IR_CAPTURE  4'h1
`define BST_IR_IDCODE   4'h1
`define BST_IR_USER     4'h2
`define BST_IR_STATUS   4'h3
`define BST_IR_BYPASS   4'hf

// ============================================================
// Data path sizes
`define BST_DR_W        32
`define BST_FIFO_DEPTH  16
`define BST_IDCODE_VAL  32'h0000_0001

`endif

// File: bst_pkg.sv
package bst_pkg;

  // ============================================================
  // Test port controller states
  typedef enum logic [3:0]
  {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } bst_tap_state_type;

endpackage

// File: bst_fifo.sv
`timescale 1ns/1ps

module bst_fifo
#(
  parameter int W     = 32,
  parameter int DEPTH = 16
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             count;
  } bst_fifo_state_type;

  bst_fifo_state_type r;
  bst_fifo_state_type next_r;

  logic push;
  logic pop;

  // ============================================================
  // Flags come straight from the count, so full and empty are exact
  assign o_ready = (r.count != (AW+1)'(DEPTH));
  assign o_valid = (r.count != '0);
  assign o_data  = r.mem[r.rd];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb
  begin
    next_r = r;
    if (push)
    begin
      next_r.mem[r.wr] = i_data;
      next_r.wr        = (r.wr == AW'(DEPTH-1)) ? '0 : r.wr + 1'b1;
    end
    if (pop)
    begin
      next_r.rd = (r.rd == AW'(DEPTH-1)) ? '0 : r.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_r.count = r.count + 1'b1;
      2'b01:   next_r.count = r.count - 1'b1;
      default: next_r.count = r.count;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      r <= '0;
    else if (i_ce)
      r <= next_r;
  end

endmodule

// File: bst_tap_top.sv
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_tap_top
#(
  parameter int              DR_W       = `BST_DR_W,
  parameter int              FIFO_DEPTH = `BST_FIFO_DEPTH,
  parameter logic [DR_W-1:0] IDCODE_VAL = `BST_IDCODE_VAL  // Arbitrary value
)
(
  input  wire logic            I_CLK,
  input  wire logic            I_RST,
  input  wire logic            I_CE,
  input  wire logic            I_TCK,
  input  wire logic            I_TRST_N,
  input  wire logic            I_TMS,
  input  wire logic            I_TDI,
  output logic                 O_TDO,
  output logic                 O_TDO_OE,
  output logic [DR_W-1:0]      O_DATA,
  output logic                 O_VALID,
  input  wire logic            I_READY
);

  typedef struct packed
  {
    bst_pkg::bst_tap_state_type state;
    logic [`BST_IR_W-1:0]       ir;
    logic [`BST_IR_W-1:0]       ir_sh;
    logic [DR_W-1:0]            dr_sh;
    logic [DR_W-1:0]            upd_data;
    logic [DR_W-1:0]            xfer;
    logic                       req;
    logic                       ack1;
    logic                       ack2;
    logic                       ack3;
    logic                       ack_seen;
  } bst_tck_state_type;

  typedef struct packed
  {
    logic tdo;
    logic tdo_oe;
  } bst_out_state_type;

  typedef struct packed
  {
    logic req1;
    logic req2;
    logic req3;
    logic ack;
  } bst_sys_state_type;

  bst_tck_state_type t;
  bst_tck_state_type next_t;
  bst_out_state_type o;
  bst_out_state_type next_o;
  bst_sys_state_type s;
  bst_sys_state_type next_s;

  logic busy;
  logic pending;
  logic fifo_ready;
  logic is_bypass;

  assign busy      = t.req ^ t.ack_seen;
  assign is_bypass = (t.ir != `BST_IR_IDCODE) && (t.ir != `BST_IR_USER) && (t.ir != `BST_IR_STATUS);

  // ============================================================
  // Controller on the test clock
  always_comb
  begin
    next_t = t;
    case (t.state)
      bst_pkg::TEST_LOGIC_RESET: next_t.state = I_TMS ? bst_pkg::TEST_LOGIC_RESET : bst_pkg::RUN_TEST_IDLE;
      bst_pkg::RUN_TEST_IDLE:    next_t.state = I_TMS ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
      bst_pkg::SELECT_DR:        next_t.state = I_TMS ? bst_pkg::SELECT_IR : bst_pkg::CAPTURE_DR;
      bst_pkg::CAPTURE_DR:       next_t.state = I_TMS ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
      bst_pkg::SHIFT_DR:         next_t.state = I_TMS ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
      bst_pkg::EXIT1_DR:         next_t.state = I_TMS ? bst_pkg::UPDATE_DR : bst_pkg::PAUSE_DR;
      bst_pkg::PAUSE_DR:         next_t.state = I_TMS ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
      bst_pkg::EXIT2_DR:         next_t.state = I_TMS ? bst_pkg::UPDATE_DR : bst_pkg::SHIFT_DR;
      bst_pkg::UPDATE_DR:        next_t.state = I_TMS ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
      bst_pkg::SELECT_IR:        next_t.state = I_TMS ? bst_pkg::TEST_LOGIC_RESET : bst_pkg::CAPTURE_IR;
      bst_pkg::CAPTURE_IR:       next_t.state = I_TMS ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
      bst_pkg::SHIFT_IR:         next_t.state = I_TMS ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
      bst_pkg::EXIT1_IR:         next_t.state = I_TMS ? bst_pkg::UPDATE_IR : bst_pkg::PAUSE_IR;
      bst_pkg::PAUSE_IR:         next_t.state = I_TMS ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
      bst_pkg::EXIT2_IR:         next_t.state = I_TMS ? bst_pkg::UPDATE_IR : bst_pkg::SHIFT_IR;
      bst_pkg::UPDATE_IR:        next_t.state = I_TMS ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
      default:                   next_t.state = bst_pkg::TEST_LOGIC_RESET;
    endcase

    case (t.state)
      bst_pkg::TEST_LOGIC_RESET:
      begin
        next_t.ir = `BST_IR_IDCODE;
      end
      bst_pkg::CAPTURE_IR:
      begin
        next_t.ir_sh = `BST_IR_CAPTURE;
      end
      bst_pkg::SHIFT_IR:
      begin
        next_t.ir_sh = {I_TDI, t.ir_sh[`BST_IR_W-1:1]};
      end
      bst_pkg::UPDATE_IR:
      begin
        next_t.ir = t.ir_sh;
      end
      bst_pkg::CAPTURE_DR:
      begin
        case (t.ir)
          `BST_IR_IDCODE: next_t.dr_sh = IDCODE_VAL;
          `BST_IR_USER:   next_t.dr_sh = t.upd_data;
          `BST_IR_STATUS: next_t.dr_sh = {{(DR_W-1){1'b0}}, busy};
          default:        next_t.dr_sh = '0;
        endcase
      end
      bst_pkg::SHIFT_DR:
      begin
        // Bypass is a single stage, the other paths are full width
        if (is_bypass)
          next_t.dr_sh[0] = I_TDI;
        else
          next_t.dr_sh = {I_TDI, t.dr_sh[DR_W-1:1]};
      end
      bst_pkg::UPDATE_DR:
      begin
        if (t.ir == `BST_IR_USER)
        begin
          next_t.upd_data = t.dr_sh;
          // Word is held stable until the system side acknowledges it
          if (!busy)
          begin
            next_t.xfer = t.dr_sh;
            next_t.req  = ~t.req;
          end
        end
      end
      default:
      begin
        next_t.ir = t.ir;
      end
    endcase

    next_t.ack1 = s.ack;
    next_t.ack2 = t.ack1;
    next_t.ack3 = t.ack2;
    if (t.ack2 == t.ack3)
      next_t.ack_seen = t.ack3;
  end

  always_ff @(posedge I_TCK or negedge I_TRST_N)
  begin
    if (!I_TRST_N)
      t <= '{state: bst_pkg::TEST_LOGIC_RESET, ir: `BST_IR_IDCODE, default: '0};
    else
      t <= next_t;
  end

  // ============================================================
  // Serial output, launched half a test clock before it is sampled
  always_comb
  begin
    next_o.tdo    = (t.state == bst_pkg::SHIFT_IR) ? t.ir_sh[0] : t.dr_sh[0];
    next_o.tdo_oe = (t.state == bst_pkg::SHIFT_IR) || (t.state == bst_pkg::SHIFT_DR);
  end

  always_ff @(negedge I_TCK or negedge I_TRST_N)
  begin
    if (!I_TRST_N)
      o <= '0;
    else
      o <= next_o;
  end

  assign O_TDO    = o.tdo;
  assign O_TDO_OE = o.tdo_oe;

  // ============================================================
  // System side of the handshake
  assign pending = (s.req2 == s.req3) && (s.req3 != s.ack);

  always_comb
  begin
    next_s      = s;
    next_s.req1 = t.req;
    next_s.req2 = s.req1;
    next_s.req3 = s.req2;
    // No acknowledge until the FIFO takes the word, so back-pressure reaches the port
    if (pending && fifo_ready)
      next_s.ack = s.req3;
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      s <= '0;
    else if (I_CE)
      s <= next_s;
  end

  bst_fifo
  #(
    .W     (DR_W),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_data  (t.xfer),
    .i_valid (pending),
    .o_ready (fifo_ready),
    .o_data  (O_DATA),
    .o_valid (O_VALID),
    .i_ready (I_READY)
  );

endmodule

// File: bst_tap_monitor.sv
`timescale 1ns/1ps

module bst_tap_monitor
#(
  parameter int DR_W = 32
)
(
  input wire logic            I_CLK,
  input wire logic            I_RST,
  input wire logic            I_CE,
  input wire logic            I_TCK,
  input wire logic            I_TRST_N,
  input wire logic            I_TMS,
  input wire logic            I_TDI,
  input wire logic            O_TDO,
  input wire logic            O_TDO_OE,
  input wire logic [DR_W-1:0] O_DATA,
  input wire logic            O_VALID,
  input wire logic            I_READY
);
  // ============================================================
  // Test port
  a_trst_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    !I_TRST_N |-> !O_TDO_OE && !O_TDO) else $error("tdo active in test reset");
  // Sampled on the fast clock so a rising-edge change is caught
  a_tdo_fall: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_TRST_N && $past(I_TRST_N) && $changed(O_TDO) |-> !I_TCK) else $error("tdo moved on rising tck");
  a_oe_fall: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_TRST_N && $past(I_TRST_N) && $changed(O_TDO_OE) |-> !I_TCK) else $error("oe moved on rising tck");
  a_oe_hold: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    O_TDO_OE && !I_TMS |=> O_TDO_OE) else $error("oe dropped while shifting");
  a_oe_exit: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    O_TDO_OE && I_TMS |=> !O_TDO_OE) else $error("oe kept after shift exit");
  // From reset, low high low low must land in data shift
  a_tms_reset: assert property (@(posedge I_TCK) disable iff (!I_TRST_N)
    I_TMS [*5] ##1 !I_TMS ##1 I_TMS ##1 !I_TMS ##1 !I_TMS |=> O_TDO_OE) else $error("no shift after mode reset");
  // ============================================================
  // Output stream
  a_fifo_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_VALID && !(I_READY && I_CE) |=> O_VALID && $stable(O_DATA)) else $error("head word lost");
  a_ce_freeze: assert property (@(posedge I_CLK) disable iff (I_RST)
    !I_CE |=> $stable(O_VALID) && $stable(O_DATA)) else $error("state moved without enable");
  c_shift: cover property (@(posedge I_TCK) $rose(O_TDO_OE));
  c_pop: cover property (@(posedge I_CLK) O_VALID && I_READY && I_CE);
  c_trst: cover property (@(posedge I_CLK) O_TDO_OE ##1 !I_TRST_N);
endmodule

// File: bst_ctl_model.sv
`timescale 1ns/1ps

module bst_ctl_model
(
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  // Clock stands still low between frames
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #15;
    tdo   = i_tdo;
    o_tck = 1'b1;
    #15;
    o_tck = 1'b0;
  endtask
  // From idle or reset; ends idle with a few clocks for the ack to return
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = '0;
    step(1'b0, 1'b1, d);
    step(1'b1, 1'b1, d);
    if (ir)
      step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
    step(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, 1'b1, d);
    repeat (6) step(1'b0, 1'b1, d);
  endtask
endmodule

// File: bst_tap_top_bench.sv
`timescale 1ns/1ps

module bst_tap_top_bench;
  localparam logic [31:0] ID = 32'h5a3c_0f01;  // Arbitrary value
  logic        clk;
  logic        rst;
  logic        ce;
  logic        rdy;
  logic        trst_n;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        oe;
  logic        vld;
  logic [31:0] data;
  logic [31:0] d;
  logic        pin;
  int          miscompares;
  int          comparisons;

  // Released pin shows the inverse, so a sample outside shifting is caught
  assign pin = oe ? tdo : !tdo;

  bst_ctl_model ctl_u (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(pin));
  bst_tap_top #(.IDCODE_VAL(ID)) dut_u (.I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_TCK(tck), .I_TRST_N(trst_n),
    .I_TMS(tms), .I_TDI(tdi), .O_TDO(tdo), .O_TDO_OE(oe), .O_DATA(data), .O_VALID(vld), .I_READY(rdy));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_bypass;
    logic x;
    ctl_u.scan(1'b1, 4, 32'hf, d);
    chk("ir capture", 32'h1, d);
    ctl_u.scan(1'b0, 8, 32'hb5, d);
    chk("bypass", 32'h6a, d);
    // Five mode-select highs bring back the identity instruction
    repeat (5) ctl_u.step(1'b1, 1'b1, x);
    ctl_u.scan(1'b0, 32, 32'h0, d);
    chk("tms reset", ID, d);
  endtask
  // Reset mid-shift must release tdo at once, no clock
  task automatic t_trst;
    logic x;
    ctl_u.step(1'b1, 1'b1, x);
    ctl_u.step(1'b0, 1'b1, x);
    ctl_u.step(1'b0, 1'b1, x);
    #1;
    chk("oe shift", 32'h1, {31'h0, oe});
    repeat (2) @(negedge clk);
    trst_n = 1'b0;
    #1;
    chk("oe trst", 32'h0, {31'h0, oe});
    @(negedge clk);
    trst_n = 1'b1;
    ctl_u.scan(1'b0, 32, 32'h0, d);
    chk("idcode", ID, d);
    chk("oe idle", 32'h0, {31'h0, oe});
  endtask
  // Seventeen words into sixteen slots; the last waits as busy
  task automatic t_fill;
    logic x;
    ctl_u.scan(1'b1, 4, 32'h2, d);
    for (int i = 0; i < 17; i++)
    begin
      ctl_u.scan(1'b0, 32, 32'hc0de_0000 + i, d);
      if (i > 0)
        chk("user", 32'hc0de_0000 + i - 1, d);
    end
    ctl_u.scan(1'b1, 4, 32'h3, d);
    ctl_u.scan(1'b0, 32, 32'h0, d);
    chk("busy", 32'h1, d & 32'h1);
    @(negedge clk);
    ce  = 1'b0;
    rdy = 1'b1;
    repeat (3) @(negedge clk);
    chk("ce hold", 32'hc0de_0000, data);
    ce  = 1'b1;
    // Ready stays up; every head word is looked at before the edge that pops it
    for (int i = 0; i < 17; i++)
    begin
      for (int k = 0; k < 50 && vld !== 1'b1; k++)
        @(negedge clk);
      chk("word", 32'hc0de_0000 + i, data);
      @(negedge clk);
    end
    rdy = 1'b0;
    repeat (8) @(negedge clk);
    chk("empty", 32'h0, {31'h0, vld});
    // Acknowledge only crosses on test clock edges, so give it a few
    repeat (4) ctl_u.step(1'b0, 1'b1, x);
    ctl_u.scan(1'b0, 32, 32'h0, d);
    chk("idle", 32'h0, d & 32'h1);
  endtask
  initial
  begin
    rst    = 1'b1;
    trst_n = 1'b0;
    ce     = 1'b1;
    rdy    = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst    = 1'b0;
    trst_n = 1'b1;
    t_bypass();
    t_trst();
    t_fill();
    summarize();
  end
  // Tests need about 30 us
  initial
  begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule

bind bst_tap_top bst_tap_monitor #(.DR_W(DR_W)) mon_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_TCK(I_TCK),
  .I_TRST_N(I_TRST_N), .I_TMS(I_TMS), .I_TDI(I_TDI), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .O_DATA(O_DATA),
  .O_VALID(O_VALID), .I_READY(I_READY));
